// >>> etc_defines.svh
// timing and reset constants for the emulator takeover block
`ifndef ETC_DEFINES_SVH
`define ETC_DEFINES_SVH
`define ETC_MODE_W 3
`define ETC_MODE_RST 3'h0
`define ETC_BOOT_A_BIT 0
`define ETC_CLK_NS 40
`define ETC_GRANT_NS 40
`define ETC_GRANT_CYC (((`ETC_GRANT_NS) + (`ETC_CLK_NS) - 1) / (`ETC_CLK_NS))
`endif

// >>> etc_pkg.sv
// types for the emulator takeover block
package etc_pkg;
  typedef enum logic [1:0] {
    ETC_RUN = 2'b00,
    ETC_GRANTED = 2'b01
  } etc_bus_state_t;
  typedef struct packed {
    logic reset;
    logic bus_request;
  } etc_sel_t;
endpackage

// >>> etc_path_select.sv
// registered selection of normal or emulation reset and request paths
`timescale 1ns/1ps
`default_nettype none
module etc_path_select (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // selection
  input wire logic emu_active_i,
  input wire logic ignore_target_i,
  // candidate paths, active high
  input wire etc_pkg::etc_sel_t target_i,
  input wire etc_pkg::etc_sel_t emu_i,
  // registered choice
  output var etc_pkg::etc_sel_t sel_o
);
  etc_pkg::etc_sel_t next_sel;
  always_comb begin
    if (emu_active_i) begin
      next_sel = emu_i;
    end else if (ignore_target_i) begin
      next_sel = '0;
    end else begin
      next_sel = target_i;
    end
  end
  // registered so a path switch cannot glitch internal reset or grant
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_o <= '0;
    end else begin
      sel_o <= next_sel;
    end
  end
endmodule
`default_nettype wire

// >>> etc_takeover.sv
// emulator takeover control: reset, bus request and grant path switching
`include "etc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - emulator chip reset fully resets the chip and re-latches memory mode pins.
// - mode latched on emulator reset exactly as on normal reset.
// - emulator enable input puts the device under emulator control.
// - under emulation use emulation reset, request, grant; three-state normal grant.
// - emulation pins have no effect outside emulation.
// - single-step ignores target reset and target bus request.
// - halted in emulator space ignores target reset and bus request.
// - target takes bus only when grant is actually asserted.
// - idle device answers the request pin on the second clock edge: float buses, grant, halt.
// - request release drops grant, re-enables drivers, resumes execution.
module etc_takeover (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // target side, active low pins
  input wire logic target_reset_n_i,
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o,
  output logic bus_grant_oe_n_o,
  // emulator side, active low pins
  input wire logic emulator_enable_n_in_i,
  input wire logic emulation_reset_n_in_i,
  input wire logic emulation_bus_request_n_in_i,
  output logic emulation_bus_grant_n_out_o,
  // core status
  input wire logic single_step_i,
  input wire logic emu_halted_i,
  input wire logic ext_access_busy_i,
  input wire logic [`ETC_MODE_W-1:0] mode_pins_i,
  // core control
  output logic chip_reset_o,
  output logic [`ETC_MODE_W-1:0] mode_latched_o,
  output logic bus_float_o,
  output logic core_halt_o,
  output logic emu_active_o
);
  etc_pkg::etc_sel_t tgt, emu, sel;
  etc_pkg::etc_bus_state_t state, next_state;
  logic emu_en, next_emu_en;
  logic ign, grant;
  logic next_reset;
  logic [`ETC_MODE_W-1:0] next_mode;
  logic next_gnt_n, next_gnt_oe_n, next_egnt_n, next_float, next_halt;

  assign tgt.reset = ~target_reset_n_i;
  assign tgt.bus_request = ~bus_request_n_i;
  assign emu.reset = ~emulation_reset_n_in_i;
  assign emu.bus_request = ~emulation_bus_request_n_in_i;
  // target pins are dropped in step or halt even if emulation just left
  assign ign = single_step_i | emu_halted_i;

  etc_path_select u_sel (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .emu_active_i(emu_en),
    .ignore_target_i(ign),
    .target_i(tgt),
    .emu_i(emu),
    .sel_o(sel)
  );

  // enable register
  always_comb begin
    next_emu_en = ~emulator_enable_n_in_i;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      emu_en <= 1'b0;
    end else begin
      emu_en <= next_emu_en;
    end
  end

  // reset and mode latch: same path for either reset source
  always_comb begin
    next_reset = sel.reset;
    next_mode = mode_latched_o;
    if (sel.reset) begin
      next_mode = mode_pins_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_reset_o <= 1'b1;
      mode_latched_o <= `ETC_MODE_RST;
    end else begin
      chip_reset_o <= next_reset;
      mode_latched_o <= next_mode;
    end
  end

  // bus grant state; request keeps working even during reset
  always_comb begin
    next_state = state;
    case (state)
      etc_pkg::ETC_RUN: begin
        if (sel.bus_request && !ext_access_busy_i) begin
          next_state = etc_pkg::ETC_GRANTED;
        end
      end
      etc_pkg::ETC_GRANTED: begin
        if (!sel.bus_request) begin
          next_state = etc_pkg::ETC_RUN;
        end
      end
      default: next_state = etc_pkg::ETC_RUN;
    endcase
  end
  assign grant = (next_state == etc_pkg::ETC_GRANTED);
  always_comb begin
    next_float = grant;
    next_halt = grant;
    next_gnt_n = ~(grant & ~emu_en);
    next_gnt_oe_n = emu_en;
    next_egnt_n = ~(grant & emu_en);
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= etc_pkg::ETC_RUN;
      bus_float_o <= 1'b0;
      core_halt_o <= 1'b0;
      bus_grant_n_o <= 1'b1;
      bus_grant_oe_n_o <= 1'b0;
      emulation_bus_grant_n_out_o <= 1'b1;
      emu_active_o <= 1'b0;
    end else begin
      state <= next_state;
      bus_float_o <= next_float;
      core_halt_o <= next_halt;
      bus_grant_n_o <= next_gnt_n;
      bus_grant_oe_n_o <= next_gnt_oe_n;
      emulation_bus_grant_n_out_o <= next_egnt_n;
      emu_active_o <= emu_en;
    end
  end

  property p_grant_float;
    @(posedge clk_sys_i) disable iff (!nrst_i) (state == etc_pkg::ETC_GRANTED) |-> (bus_float_o && core_halt_o);
  endproperty
  a_grant_float: assert property (p_grant_float) else $error("grant without float or halt");
  property p_release;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (state == etc_pkg::ETC_GRANTED && !sel.bus_request) |=> (!core_halt_o && !bus_float_o);
  endproperty
  a_release: assert property (p_release) else $error("release did not resume");
  property p_oe_emu;
    @(posedge clk_sys_i) disable iff (!nrst_i) emu_en |=> bus_grant_oe_n_o;
  endproperty
  a_oe_emu: assert property (p_oe_emu) else $error("normal grant driven in emulation");
  property p_egnt_inert;
    @(posedge clk_sys_i) disable iff (!nrst_i) !emu_en |=> emulation_bus_grant_n_out_o;
  endproperty
  a_egnt_inert: assert property (p_egnt_inert) else $error("emulation grant outside emulation");
  property p_ignore;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!emu_en && ign) |=> !sel.reset && !sel.bus_request;
  endproperty
  a_ignore: assert property (p_ignore) else $error("target input seen while stepping");
  property p_mode;
    @(posedge clk_sys_i) disable iff (!nrst_i) sel.reset |=> (mode_latched_o == $past(mode_pins_i));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not latched on reset");
  property p_reset_follow;
    @(posedge clk_sys_i) disable iff (!nrst_i) (emu_en && emu.reset) |=> ##1 chip_reset_o;
  endproperty
  a_reset_follow: assert property (p_reset_follow) else $error("emulator reset missed");
  property p_grant_bound;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (sel.bus_request && !ext_access_busy_i && state == etc_pkg::ETC_RUN) |=> ##[0:1] core_halt_o;
  endproperty
  a_grant_bound: assert property (p_grant_bound) else $error("late grant");

  // normal grant pin must be driven again once the emulator lets go
  property p_oe_normal;
    @(posedge clk_sys_i) disable iff (!nrst_i) !emu_en |=> !bus_grant_oe_n_o;
  endproperty
  a_oe_normal: assert property (p_oe_normal) else $error("normal grant floated outside emulation");
  property p_emu_grant_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (emu_en && sel.bus_request && state == etc_pkg::ETC_GRANTED) |=> !emulation_bus_grant_n_out_o;
  endproperty
  a_emu_grant_hold: assert property (p_emu_grant_hold) else $error("emulation grant dropped");
  property p_reset_inert;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!emu_en && !ign && !tgt.reset) |=> !sel.reset;
  endproperty
  a_reset_inert: assert property (p_reset_inert) else $error("emulation reset seen outside emulation");
  property p_request_inert;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!emu_en && !ign && !tgt.bus_request) |=> !sel.bus_request;
  endproperty
  a_request_inert: assert property (p_request_inert) else $error("emulation request seen outside emulation");
  property p_halt_ignore;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!emu_en && emu_halted_i) |=> !sel.reset && !sel.bus_request;
  endproperty
  a_halt_ignore: assert property (p_halt_ignore) else $error("target input seen while halted");
  property p_float_grant;
    @(posedge clk_sys_i) disable iff (!nrst_i) bus_float_o |-> (!bus_grant_n_o || !emulation_bus_grant_n_out_o);
  endproperty
  a_float_grant: assert property (p_float_grant) else $error("bus floated without a grant");
  property p_busy_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (state == etc_pkg::ETC_RUN && ext_access_busy_i) |=> !core_halt_o;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("grant during external access");
  property p_grant_stay;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (state == etc_pkg::ETC_GRANTED && sel.bus_request) |=> core_halt_o;
  endproperty
  a_grant_stay: assert property (p_grant_stay) else $error("grant dropped while requested");
  property p_chip_reset;
    @(posedge clk_sys_i) disable iff (!nrst_i) sel.reset |=> chip_reset_o;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("selected reset did not reach the chip");

  c_emu_grant: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) !emulation_bus_grant_n_out_o);
  c_tgt_grant: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) !bus_grant_n_o);
  c_emu_reset: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) emu_en && sel.reset);
  c_busy_wait: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state == etc_pkg::ETC_RUN && sel.bus_request && ext_access_busy_i);
endmodule
`default_nettype wire

// >>> etc_emu_probe.sv
// emulator probe model driving the emulation pins
`timescale 1ns/1ps
`default_nettype none
module etc_emu_probe (
  // clock
  input wire logic clk_sys_i,
  // commands from the bench
  input wire logic take_i,
  input wire logic reset_i,
  input wire logic request_i,
  // emulation pins, active low
  output logic emulator_enable_n_o,
  output logic emulation_reset_n_o,
  output logic emulation_bus_request_n_o
);
  initial begin
    emulator_enable_n_o = 1'b1;
    emulation_reset_n_o = 1'b1;
    emulation_bus_request_n_o = 1'b1;
  end
  // pins move just after the edge, like the real probe logic
  always @(posedge clk_sys_i) begin
    emulator_enable_n_o <= #1 ~take_i;
    emulation_reset_n_o <= #1 ~reset_i;
    emulation_bus_request_n_o <= #1 ~request_i;
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the emulator takeover block
`include "etc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i = 0, nrst_i = 0, trst_n = 1, br_n = 1, step = 0, halt = 0, busy = 0;
  logic take = 0, erst = 0, emulation_bus_request_in = 0;
  logic [`ETC_MODE_W-1:0] mode = 3'h0;
  logic [`ETC_MODE_W-1:0] ml;
  logic ee_n, er_n, ebr_n, bg_n, oe_n, ebg_n, crst, flt, hlt, act;
  int fails = 0, comparisons = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  etc_emu_probe probe (.clk_sys_i(clk_sys_i), .take_i(take), .reset_i(erst), .request_i(emulation_bus_request_in),
    .emulator_enable_n_o(ee_n), .emulation_reset_n_o(er_n), .emulation_bus_request_n_o(ebr_n));
  etc_takeover dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .target_reset_n_i(trst_n),
    .bus_request_n_i(br_n), .bus_grant_n_o(bg_n), .bus_grant_oe_n_o(oe_n),
    .emulator_enable_n_in_i(ee_n), .emulation_reset_n_in_i(er_n),
    .emulation_bus_request_n_in_i(ebr_n), .emulation_bus_grant_n_out_o(ebg_n),
    .single_step_i(step), .emu_halted_i(halt), .ext_access_busy_i(busy), .mode_pins_i(mode),
    .chip_reset_o(crst), .mode_latched_o(ml), .bus_float_o(flt), .core_halt_o(hlt),
    .emu_active_o(act));
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic finish_test;
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_grant;
    br_n = 0;
    tick(2);
    chk("grant", {1'b0, bg_n, flt, hlt}, 4'h3);
    br_n = 1;
    tick(2);
    chk("release", {1'b0, bg_n, flt, hlt}, 4'h4);
    busy = 1;
    br_n = 0;
    tick(3);
    chk("busy grant", {3'h0, bg_n}, 4'h1);
    busy = 0;
    tick(2);
    chk("late grant", {3'h0, bg_n}, 4'h0);
    br_n = 1;
    tick(3);
  endtask
  task automatic t_inert;
    emulation_bus_request_in = 1;
    erst = 1;
    tick(4);
    chk("inert", {1'b0, bg_n, ebg_n, crst}, 4'h6);
    emulation_bus_request_in = 0;
    erst = 0;
    tick(3);
  endtask
  task automatic t_ignore;
    for (int i = 0; i < 2; i++) begin
      step = (i == 0);
      halt = (i == 1);
      br_n = 0;
      trst_n = 0;
      tick(3);
      chk("ignored", {2'h0, bg_n, crst}, 4'h2);
      br_n = 1;
      trst_n = 1;
      tick(2);
    end
    step = 0;
    halt = 0;
  endtask
  task automatic t_reset;
    // board sets mode pins before any reset
    mode = 3'h2;
    trst_n = 0;
    tick(3);
    chk("normal reset", {crst, ml}, 4'hA);
    trst_n = 1;
    tick(3);
  endtask
  task automatic t_emu;
    take = 1;
    tick(5);
    chk("takeover", {2'h0, oe_n, act}, 4'h3);
    br_n = 0;
    trst_n = 0;
    tick(3);
    chk("target pins", {1'b0, bg_n, ebg_n, crst}, 4'h6);
    br_n = 1;
    trst_n = 1;
    emulation_bus_request_in = 1;
    tick(4);
    chk("emu grant", {2'h0, ebg_n, flt}, 4'h1);
    emulation_bus_request_in = 0;
    tick(4);
    mode = 3'h4;
    erst = 1;
    tick(4);
    chk("emu reset", {crst, ml}, 4'hC);
    erst = 0;
    take = 0;
    tick(6);
    chk("handback", {2'h0, oe_n, act}, 4'h0);
  endtask
  initial begin
    tick(10);
    nrst_i = 1;
    tick(3);
    t_grant();
    t_inert();
    t_ignore();
    t_reset();
    t_emu();
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
